// [bench/fbd_decoder_props.sv]
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module fbd_decoder_props
  import fbd_pkg::*;
#(
  parameter int IW = 14
) (
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire logic          instr_valid,
  input wire logic [IW-1:0] instr,
  input wire logic [7:0]    w_in,
  input wire logic [7:0]    f_in,
  input wire logic          carry_in,
  input wire logic [1:0]    ptr_msb,
  input wire logic          instr_ready,
  input wire logic          exec_valid,
  input wire fbd_exec_t     exec_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  fbd_exec_t  e;
  logic       disc_r;
  logic       disc_nxt;
  logic       dnow;
  logic       tk;
  logic       bhit;
  logic [2:0] bix;
  logic [7:0] bmask;
  logic [7:0] bmod;
  assign e     = exec_out;
  // A skip stays pending until some word arrives to be dropped
  assign dnow  = disc_r || (exec_valid && e.skip);
  assign tk    = instr_valid && instr_ready && !dnow && ptr_msb == 2'h0;
  assign bix   = instr[9:7];
  assign bmask = 8'h01 << bix;
  assign bhit  = f_in[bix] == instr[10];
  assign bmod  = instr[10] ? (f_in | bmask) : (f_in & ~bmask);
  always_comb disc_nxt = dnow && !(instr_valid && instr_ready);
  always_ff @(posedge clk) disc_r <= sys_rst ? 1'b0 : disc_nxt;
  ////////////////////////////////////////////////////////////////////////////
  add_sum_a: assert property (tk && instr[13:8] == 6'h3d |=> exec_valid
    && e.c_upd && e.dc_upd && e.z_upd
    && e.result == $past(w_in) + $past(f_in) + $past(carry_in))
    else $error("add result wrong");
  or_reg_a: assert property (tk && instr[13:8] == 6'h04 |=> exec_valid
    && e.wr_f == $past(instr[7]) && e.wr_w == !$past(instr[7])
    && e.result == ($past(w_in) | $past(f_in)))
    else $error("or to destination wrong");
  zero_only_a: assert property (exec_valid && e.op inside {or_reg_op,
    exclusive_or_reg_op, or_literal_op, exclusive_or_literal_op}
    |-> e.z_upd && !e.c_upd && !e.dc_upd && e.z == (e.result == 8'h00))
    else $error("logic flags wrong");
  rot_flag_a: assert property (exec_valid
    && e.op inside {rotate_left_op, rotate_right_op} |-> e.c_upd && !e.dc_upd && !e.z_upd)
    else $error("rotate flags wrong");
  asr_sign_a: assert property (tk && instr[13:8] == 6'h37 |=> exec_valid && !e.dc_upd
    && e.result == (($past(f_in) >> 1) | ($past(f_in) & 8'h80)))
    else $error("shift lost sign");
  skip_zero_a: assert property (exec_valid
    && e.op inside {decrement_skip_zero_op, increment_skip_zero_op}
    |-> e.skip == (e.result == 8'h00) && !e.z_upd && !e.c_upd)
    else $error("count skip wrong");
  skip_drop_a: assert property (exec_valid && e.skip && instr_valid |=> !exec_valid)
    else $error("skipped word ran");
  bit_test_a: assert property (tk && instr[13:11] == 3'h3 |=> exec_valid
    && e.skip == $past(bhit) && !e.wr_f && !e.z_upd)
    else $error("bit test skip wrong");
  bit_mod_a: assert property (tk && instr[13:11] == 3'h2 |=> exec_valid
    && e.result == $past(bmod) && !e.z_upd && !e.c_upd)
    else $error("bit change wrong");
  pch_load_a: assert property (tk && instr[13:8] == 6'h31 |=> exec_valid && e.pch_wr
    && e.pch == $past(instr[6:0]) && !e.z_upd)
    else $error("high latch load wrong");
  stretch_a: assert property (instr_valid && instr_ready && !dnow
    && instr[13:8] == 6'h04 && instr[6:0] == 7'h00 && ptr_msb[0]
    |=> !instr_ready && !exec_valid ##1 exec_valid && instr_ready)
    else $error("indirect stretch wrong");
endmodule
bind fbd_decoder fbd_decoder_props #(.IW(IW)) u_props (.clk(clk), .sys_rst(sys_rst),
  .instr_valid(instr_valid), .instr(instr), .w_in(w_in), .f_in(f_in), .carry_in(carry_in),
  .ptr_msb(ptr_msb), .instr_ready(instr_ready), .exec_valid(exec_valid), .exec_out(exec_out));
`default_nettype wire

// [bench/fbd_prog_mem.sv]
// Program memory model feeding instruction words
`timescale 1ns/1ps
`default_nettype none
module fbd_prog_mem (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        instr_ready,
  output var  logic        instr_valid,
  output var  logic [13:0] instr
);
  logic [13:0] q[$];
  logic [13:0] last;
  logic        slow, idle, tk;
  initial begin
    instr_valid = 1'b0;
    instr = 14'h0;
    last = 14'h0;
    slow = 1'b0;
    idle = 1'b0;
  end
  // A word is held until taken; slow mode idles only between words
  always @(posedge clk) begin
    tk = instr_valid && instr_ready;
    #1;
    if (tk) void'(q.pop_front());
    idle = slow && !idle && (tk || !instr_valid);
    if (!sys_rst && !idle && q.size() > 0) begin
      instr_valid = 1'b1;
      instr = q[0];
      last = q[0];
    end else begin
      instr_valid = 1'b0;
      instr = ~last;
    end
  end
endmodule
`default_nettype wire

// [bench/fourteen_bit_instruction_decoder_bench.sv]
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module fourteen_bit_instruction_decoder_bench
  import fbd_pkg::*;
;
  logic        clk, sys_rst, instr_valid, carry_in, instr_ready, exec_valid;
  logic [13:0] instr;
  logic [7:0]  w_in, f_in;
  logic [1:0]  ptr_msb;
  fbd_exec_t   exec_out;
  int          error_cnt, samples_checked;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  fbd_decoder dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
    .w_in(w_in), .f_in(f_in), .carry_in(carry_in), .ptr_msb(ptr_msb),
    .instr_ready(instr_ready), .exec_valid(exec_valid), .exec_out(exec_out));
  fbd_prog_mem pm (.clk(clk), .sys_rst(sys_rst), .instr_ready(instr_ready),
    .instr_valid(instr_valid), .instr(instr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Flags are {wr_w, wr_f, c_upd, dc_upd, z_upd, c, dc, z}; c and dc only count when updated
  task automatic exe(input logic [13:0] wd, input logic [7:0] w, input logic [7:0] f,
                     input logic c, input fbd_op_t op, input logic [7:0] r,
                     input logic [7:0] fl, input logic sk);
    int          n;
    int          nr;
    logic [15:0] ph;
    logic        ind;
    n = 0;
    nr = 0;
    ph = (op == load_pc_high_op) ? 16'({1'b1, wd[6:0]}) : 16'h0000;
    ind = (wd[6:0] == 7'h00 && ptr_msb[0]) || (wd[6:0] == 7'h01 && ptr_msb[1]);
    w_in = w;
    f_in = f;
    carry_in = c;
    pm.q.push_back(wd);
    do begin
      @(posedge clk);
      #2;
      n++;
      nr += int'(!instr_ready);
    end while (!exec_valid && n < 8);
    chk("op", 16'(exec_out.op), 16'(op));
    if (!(op inside {test_skip_if_clear_op, test_skip_if_set_op, load_pc_high_op}))
      chk("result", 16'(exec_out.result), 16'(r));
    chk("flags", 16'({exec_out.wr_w, exec_out.wr_f, exec_out.c_upd, exec_out.dc_upd,
      exec_out.z_upd, exec_out.c & exec_out.c_upd, exec_out.dc & exec_out.dc_upd,
      exec_out.z}), 16'(fl));
    chk("skip", 16'(exec_out.skip), 16'(sk));
    chk("pc high", 16'({exec_out.pch_wr, exec_out.pch}), ph);
    if (wd[13:12] != 2'h3) chk("addr", 16'(exec_out.addr), 16'(wd[6:0]));
    chk("latency", 16'(n), ind ? 16'h3 : 16'h2);
    chk("stall", 16'(nr), ind ? 16'h1 : 16'h0);
    // A pending skip must swallow one word before the next row runs
    if (sk) begin
      pm.q.push_back(14'h3800);
      repeat (3) @(posedge clk);
      #2;
    end
  endtask
  task automatic t_skip(input logic sl);
    int      n;
    fbd_op_t lo;
    n = 0;
    w_in = 8'h0f;
    f_in = 8'hff;
    carry_in = 1'b0;
    pm.slow = sl;
    pm.q = {pm.q, 14'h0f85, 14'h38f0, 14'h3a0f};
    repeat (12) begin
      @(posedge clk);
      #2;
      if (exec_valid) begin
        n++;
        lo = exec_out.op;
      end
    end
    pm.slow = 1'b0;
    chk("exec count", 16'(n), 16'h2);
    chk("last op", 16'(lo), 16'(exclusive_or_literal_op));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    w_in = 8'h00;
    f_in = 8'h00;
    carry_in = 1'b0;
    ptr_msb = 2'h0;
    repeat (3) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    exe(14'h3d85, 8'h0f, 8'h01, 1'b1, add_with_carry_op, 8'h11, 8'h7a, 1'b0);
    exe(14'h3b05, 8'h01, 8'h10, 1'b1, subtract_with_borrow_op, 8'h0f, 8'hbc, 1'b0);
    exe(14'h3785, 8'h00, 8'h81, 1'b0, arith_shift_right_op, 8'hc0, 8'h6c, 1'b0);
    exe(14'h0d85, 8'h00, 8'h80, 1'b0, rotate_left_op, 8'h00, 8'h64, 1'b0);
    exe(14'h0c05, 8'h00, 8'h01, 1'b1, rotate_right_op, 8'h80, 8'ha4, 1'b0);
    exe(14'h0405, 8'hf0, 8'h0f, 1'b0, or_reg_op, 8'hff, 8'h88, 1'b0);
    exe(14'h0685, 8'h3c, 8'h3c, 1'b0, exclusive_or_reg_op, 8'h00, 8'h49, 1'b0);
    exe(14'h0b85, 8'h00, 8'h02, 1'b0, decrement_skip_zero_op, 8'h01, 8'h40, 1'b0);
    exe(14'h0f85, 8'h00, 8'hff, 1'b0, increment_skip_zero_op, 8'h00, 8'h40, 1'b1);
    exe(14'h1905, 8'h00, 8'hfb, 1'b0, test_skip_if_clear_op, 8'h00, 8'h00, 1'b1);
    exe(14'h1d05, 8'h00, 8'hfb, 1'b0, test_skip_if_set_op, 8'h00, 8'h00, 1'b0);
    exe(14'h1d05, 8'h00, 8'h04, 1'b0, test_skip_if_set_op, 8'h00, 8'h00, 1'b1);
    exe(14'h3800, 8'h00, 8'h00, 1'b0, or_literal_op, 8'h00, 8'h89, 1'b0);
    exe(14'h3c10, 8'h10, 8'h00, 1'b0, literal_minus_acc_op, 8'h00, 8'hbf, 1'b0);
    exe(14'h3105, 8'h00, 8'h00, 1'b1, load_pc_high_op, 8'h00, 8'h00, 1'b0);
    exe(14'h3a55, 8'h55, 8'h00, 1'b0, exclusive_or_literal_op, 8'h00, 8'h89, 1'b0);
    exe(14'h1185, 8'h00, 8'hff, 1'b0, bit_clear_op, 8'hf7, 8'h40, 1'b0);
    exe(14'h1405, 8'h00, 8'h00, 1'b0, bit_set_op, 8'h01, 8'h40, 1'b0);
    exe(14'h0e85, 8'h00, 8'h00, 1'b0, fbd_nop_op, 8'h00, 8'h00, 1'b0);
    ptr_msb = 2'h1;
    exe(14'h0480, 8'h01, 8'h02, 1'b0, or_reg_op, 8'h03, 8'h48, 1'b0);
    ptr_msb = 2'h2;
    exe(14'h0480, 8'h01, 8'h02, 1'b0, or_reg_op, 8'h03, 8'h48, 1'b0);
    exe(14'h0601, 8'h0f, 8'hf0, 1'b0, exclusive_or_reg_op, 8'hff, 8'h88, 1'b0);
    ptr_msb = 2'h0;
    t_skip(1'b1);
    t_skip(1'b0);
    end_sim();
  end
endmodule
`default_nettype wire

// [logic/fbd_decoder.sv]
// Instruction decoder and single-cycle execute stage for 14-bit instruction words
//
// How it works
// - Prefix 11 nibble 1101 adds W, f and carry; sets C, DC, Z.
// - Prefix 11 nibble 1011 subtracts W and borrow from f; sets C, DC, Z.
// - Prefix 11 nibble 0111 shifts f right keeping sign; sets C, Z only.
// - Prefix 00 nibbles 1101/1100 rotate f left/right through carry; C only.
// - Prefix 00 nibble 0100 ORs W with f to destination; Z only.
// - Prefix 00 nibble 0110 XORs W with f; Z only, one cycle unless indirect with pointer MSB set.
// - Decrement/increment f, skip next when result zero; no flags change.
// - Bit test skips next instruction when selected f bit is zero.
// - Bit test set skips next instruction when selected f bit is one.
// - Prefix 11 nibble 1000 ORs literal into W; Z only.
// - Prefix 11 nibble 1100 computes literal minus W into W; C, DC, Z.
// - Prefix 11 nibble 0001 loads literal into PC high latch; no flags.
// - Exclusive-or literal with W into W; Z only, one cycle.
// - A taken skip costs two cycles; second cycle runs as NOP.
// - Indirect register access with pointer MSB set adds one cycle.
// - Bit clear clears bit b (0..7) of f at 7-bit address; no flags.
`timescale 1ns/1ps
`default_nettype none
`include "fbd_params.svh"

module fbd_decoder
  import fbd_pkg::*;
#(
  parameter int IW = `FBD_IW
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          instr_valid,
  input  wire logic [IW-1:0] instr,
  input  wire logic [7:0]    w_in,
  input  wire logic [7:0]    f_in,
  input  wire logic          carry_in,
  input  wire logic [1:0]    ptr_msb,
  output logic               instr_ready,
  output logic               exec_valid,
  output fbd_exec_t          exec_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  // Returns {carry, digit carry, sum}; subtraction passes ~b, with carry-in 1 for the literal form and carry_in for borrow
  function automatic logic [9:0] fbd_add(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  function automatic logic fbd_is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode and execute

  typedef enum logic [1:0] {ST_RUN, ST_DISCARD, ST_EXTRA} fbd_state_t;

  fbd_state_t state_r;
  fbd_state_t state_nxt;
  logic       ready_r;
  logic       ready_nxt;
  logic       valid_r;
  logic       valid_nxt;
  fbd_exec_t  exec_r;
  fbd_exec_t  exec_nxt;
  fbd_exec_t  dec;
  fbd_exec_t  held_r;
  fbd_exec_t  held_nxt;
  logic [1:0] pfx;
  logic [3:0] nib;
  logic [2:0] bsel;
  logic [9:0] sum;
  logic       indirect_slow;

  assign pfx  = instr[13:12];
  assign nib  = instr[11:8];
  assign bsel = instr[9:7];

  always_comb begin
    dec          = '0;
    dec.op       = fbd_nop_op;
    dec.addr     = instr[6:0];
    sum          = 10'h000;
    case (pfx)
      `FBD_PFX_BYTE: begin
        dec.wr_f = instr[`FBD_DEST_POS];
        dec.wr_w = ~instr[`FBD_DEST_POS];
        case (nib)
          `FBD_NIB_RLEFT: begin
            dec.op     = rotate_left_op;
            dec.result = {f_in[6:0], carry_in};
            dec.c      = f_in[7];
            dec.c_upd  = 1'b1;
          end
          `FBD_NIB_RRIGHT: begin
            dec.op     = rotate_right_op;
            dec.result = {carry_in, f_in[7:1]};
            dec.c      = f_in[0];
            dec.c_upd  = 1'b1;
          end
          `FBD_NIB_OR: begin
            dec.op     = or_reg_op;
            dec.result = w_in | f_in;
            dec.z_upd  = 1'b1;
          end
          `FBD_NIB_XOR: begin
            dec.op     = exclusive_or_reg_op;
            dec.result = w_in ^ f_in;
            dec.z_upd  = 1'b1;
          end
          `FBD_NIB_DECSZ: begin
            dec.op     = decrement_skip_zero_op;
            dec.result = f_in - 8'h01;
            dec.skip   = fbd_is_zero(dec.result);
          end
          `FBD_NIB_INCSZ: begin
            dec.op     = increment_skip_zero_op;
            dec.result = f_in + 8'h01;
            dec.skip   = fbd_is_zero(dec.result);
          end
          default: begin
            dec.wr_f = 1'b0;
            dec.wr_w = 1'b0;
          end
        endcase
      end
      `FBD_PFX_BIT: begin
        case (instr[11:10])
          `FBD_BIT_CLR: begin
            dec.op     = bit_clear_op;
            dec.result = f_in & ~(8'h01 << bsel);
            dec.wr_f   = 1'b1;
          end
          `FBD_BIT_SET: begin
            dec.op     = bit_set_op;
            dec.result = f_in | (8'h01 << bsel);
            dec.wr_f   = 1'b1;
          end
          `FBD_BIT_TSTC: begin
            dec.op   = test_skip_if_clear_op;
            dec.skip = ~f_in[bsel];
          end
          default: begin
            dec.op   = test_skip_if_set_op;
            dec.skip = f_in[bsel];
          end
        endcase
      end
      `FBD_PFX_LIT: begin
        case (nib)
          `FBD_NIB_ADD_WITH_CARRY_OP: begin
            dec.op = add_with_carry_op;
            sum    = fbd_add(w_in, f_in, carry_in);
          end
          `FBD_NIB_SUBTRACT_WITH_BORROW_OP: begin
            dec.op = subtract_with_borrow_op;
            sum    = fbd_add(f_in, ~w_in, carry_in);
          end
          `FBD_NIB_ASR: begin
            dec.op     = arith_shift_right_op;
            dec.result = {f_in[7], f_in[7:1]};
            dec.c      = f_in[0];
            dec.c_upd  = 1'b1;
            dec.z_upd  = 1'b1;
          end
          `FBD_NIB_ORLIT: begin
            dec.op     = or_literal_op;
            dec.result = w_in | instr[7:0];
            dec.z_upd  = 1'b1;
          end
          `FBD_NIB_SUBLIT: begin
            dec.op = literal_minus_acc_op;
            sum    = fbd_add(instr[7:0], ~w_in, 1'b1);
          end
          `FBD_NIB_LDPCH: begin
            dec.op     = load_pc_high_op;
            dec.pch_wr = 1'b1;
            dec.pch    = instr[6:0];
          end
          `FBD_NIB_XORLIT: begin
            dec.op     = exclusive_or_literal_op;
            dec.result = w_in ^ instr[7:0];
            dec.z_upd  = 1'b1;
          end
          default: dec.op = fbd_nop_op;
        endcase
        if (dec.op == add_with_carry_op || dec.op == subtract_with_borrow_op ||
            dec.op == literal_minus_acc_op) begin
          dec.result = sum[7:0];
          dec.c      = sum[9];
          dec.dc     = sum[8];
          dec.c_upd  = 1'b1;
          dec.dc_upd = 1'b1;
          dec.z_upd  = 1'b1;
        end
        if (dec.op == add_with_carry_op || dec.op == subtract_with_borrow_op ||
            dec.op == arith_shift_right_op) begin
          dec.wr_f = instr[`FBD_DEST_POS];
          dec.wr_w = ~instr[`FBD_DEST_POS];
        end else if (dec.op == or_literal_op || dec.op == literal_minus_acc_op ||
                     dec.op == exclusive_or_literal_op) begin
          dec.wr_w = 1'b1;
        end
      end
      default: dec.op = fbd_nop_op;
    endcase
    dec.z = fbd_is_zero(dec.result);
    if (!dec.z_upd) begin
      dec.z = 1'b0;
    end
  end

  // Literal forms carry no file address, so they never stretch
  assign indirect_slow = (dec.op != fbd_nop_op) && (dec.op != or_literal_op) &&
                         (dec.op != literal_minus_acc_op) && (dec.op != load_pc_high_op) &&
                         (dec.op != exclusive_or_literal_op) &&
                         ((instr[6:0] == `FBD_IND0_ADDR && ptr_msb[0]) ||
                          (instr[6:0] == `FBD_IND1_ADDR && ptr_msb[1]));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  always_comb begin
    state_nxt = state_r;
    ready_nxt = ready_r;
    valid_nxt = 1'b0;
    exec_nxt  = exec_r;
    held_nxt  = held_r;
    case (state_r)
      ST_RUN: begin
        if (instr_valid) begin
          if (indirect_slow) begin
            held_nxt  = dec;
            ready_nxt = 1'b0;
            state_nxt = ST_EXTRA;
          end else begin
            exec_nxt  = dec;
            valid_nxt = 1'b1;
            if (dec.skip) begin
              state_nxt = ST_DISCARD;
            end
          end
        end
      end
      ST_EXTRA: begin
        // Operands were sampled on the first cycle; this one only adds latency
        exec_nxt  = held_r;
        valid_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = held_r.skip ? ST_DISCARD : ST_RUN;
      end
      ST_DISCARD: begin
        // Fetched word is dropped and this cycle runs as a NOP
        if (instr_valid) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_RUN;
      ready_r <= `FBD_RST_READY;
      valid_r <= 1'b0;
      exec_r  <= '0;
      held_r  <= '0;
    end else begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
      valid_r <= valid_nxt;
      exec_r  <= exec_nxt;
      held_r  <= held_nxt;
    end
  end

  assign instr_ready = ready_r;
  assign exec_valid  = valid_r;
  assign exec_out    = exec_r;

endmodule
`default_nettype wire

// [logic/fbd_params.svh]
// Constant values for the fourteen-bit instruction decoder
`ifndef FBD_PARAMS_SVH
`define FBD_PARAMS_SVH

`define FBD_IW            14
`define FBD_PFX_BYTE      2'h0
`define FBD_PFX_BIT       2'h1
`define FBD_PFX_LIT       2'h3
`define FBD_NIB_ADD_WITH_CARRY_OP    4'hd
`define FBD_NIB_SUBTRACT_WITH_BORROW_OP    4'hb
`define FBD_NIB_ASR       4'h7
`define FBD_NIB_RLEFT     4'hd
`define FBD_NIB_RRIGHT    4'hc
`define FBD_NIB_OR        4'h4
`define FBD_NIB_XOR       4'h6
`define FBD_NIB_DECSZ     4'hb
`define FBD_NIB_INCSZ     4'hf
`define FBD_NIB_ORLIT     4'h8
`define FBD_NIB_SUBLIT    4'hc
`define FBD_NIB_LDPCH     4'h1
`define FBD_NIB_XORLIT    4'ha
`define FBD_BIT_CLR       2'h0
`define FBD_BIT_SET       2'h1
`define FBD_BIT_TSTC      2'h2
`define FBD_BIT_TSTS      2'h3
`define FBD_DEST_POS      7
`define FBD_IND0_ADDR     7'h00
`define FBD_IND1_ADDR     7'h01
`define FBD_RST_READY     1'b1

`endif

// [logic/fbd_pkg.sv]
// Types shared by the fourteen-bit instruction decoder
package fbd_pkg;

  typedef enum logic [4:0] {
    fbd_nop_op,
    add_with_carry_op,
    subtract_with_borrow_op,
    arith_shift_right_op,
    rotate_left_op,
    rotate_right_op,
    or_reg_op,
    exclusive_or_reg_op,
    decrement_skip_zero_op,
    increment_skip_zero_op,
    test_skip_if_clear_op,
    test_skip_if_set_op,
    bit_clear_op,
    bit_set_op,
    or_literal_op,
    literal_minus_acc_op,
    load_pc_high_op,
    exclusive_or_literal_op
  } fbd_op_t;

  typedef struct packed {
    fbd_op_t    op;
    logic [7:0] result;
    logic [6:0] addr;
    logic       wr_w;
    logic       wr_f;
    logic       c_upd;
    logic       dc_upd;
    logic       z_upd;
    logic       c;
    logic       dc;
    logic       z;
    logic       pch_wr;
    logic [6:0] pch;
    logic       skip;
  } fbd_exec_t;

endpackage
